// ### design/vgapm_pkg.sv
// Package: register map, field positions and mode codes of the plane access datapath
package vgapm_pkg;
  localparam int         ADDR_W          = 16;
  localparam int         REG_ADDR_W      = 4;
  // Register offsets
  localparam logic [3:0] REG_SET_RESET   = 4'h0;
  localparam logic [3:0] REG_EN_SET_RST  = 4'h1;
  localparam logic [3:0] REG_COLOR_CMP   = 4'h2;
  localparam logic [3:0] REG_ROTATE      = 4'h3;
  localparam logic [3:0] REG_READ_PLANE  = 4'h4;
  localparam logic [3:0] REG_ACCESS_MODE = 4'h5;
  localparam logic [3:0] REG_IGNORE_MASK = 4'h7;
  localparam logic [3:0] REG_BIT_MASK    = 4'h8;
  localparam logic [3:0] REG_SEQ_MODE    = 4'h9;
  localparam logic [3:0] REG_LATCH0      = 4'ha;
  // Field positions in graphics_access_mode
  localparam int         FLD_WMODE_LO    = 0;
  localparam int         FLD_RSVD        = 2;
  localparam int         FLD_RMODE       = 3;
  localparam int         FLD_ODD_EVEN    = 4;
  // Field in data_rotate: count in [2:0]
  localparam int         FLD_ROT_HI      = 2;
  // Reset values
  localparam logic [7:0] RST_ACCESS_MODE = 8'h00;
  localparam logic [7:0] RST_BIT_MASK    = 8'hff;
  localparam logic [3:0] RST_PLANE_MASK  = 4'hf;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  // Write modes
  localparam logic [1:0] WMODE_0         = 2'h0;
  localparam logic [1:0] WMODE_1         = 2'h1;
  localparam logic [1:0] WMODE_2         = 2'h2;
  localparam logic [1:0] WMODE_3         = 2'h3;
endpackage : vgapm_pkg

// ### design/vgapm_plane_mem.sv
// Four byte planes with per-plane byte write enable and registered read
`timescale 1ns/1ps
`default_nettype none
module vgapm_plane_mem #(
  parameter int AW = 16
) (
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          wr_i,
  input  wire logic [3:0]    we_i,
  input  wire logic [31:0]   wdata_i,
  output logic      [31:0]   rdata_o
);
  logic [31:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (wr_i && we_i[p]) begin
        mem[addr_i][p*8 +: 8] <= wdata_i[p*8 +: 8];
      end
    end
    rdata_o <= mem[addr_i];
  end
endmodule // vgapm_plane_mem
`default_nettype wire

// ### design/vgapm_top.sv
// Frame buffer read/write mode datapath with its register file
//
// Overview of operation
// - With odd/even on, address bit 0 picks planes 1/3 (odd) or 0/2 (even).
// - With odd/even off, addresses walk each plane linearly under plane mask.
// - Read mode 0 returns the plane chosen by read plane select bits 1:0.
// - Read mode 1 compares each plane against its compare bit if included.
// - The compare result bit is 1 only where all included planes match.
// - Bit 2 of the access mode register always reads as 0.
// - Write mode 0 stores the rotated host byte into all four planes.
// - In write mode 0 planes with enable set/reset take the set/reset bit.
// - Write mode 1 stores the read latches, ignoring host data.
// - Read latches hold the four plane bytes of the last host read.
// - Write mode 2 uses host bits 3:0 as one colour bit per plane.
// - In write mode 2 mask 1 takes the colour, mask 0 keeps the latch.
// - Write mode 3 masks set/reset with host byte AND bit mask.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module vgapm_top
  import vgapm_pkg::*;
(
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  // Register port
  input  wire logic [vgapm_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]                       reg_wdata_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  output logic      [7:0]                       reg_rdata_o,
  // Host frame buffer port
  input  wire logic [vgapm_pkg::ADDR_W-1:0]     fb_addr_i,
  input  wire logic [7:0]                       fb_wdata_i,
  input  wire logic                             fb_wr_i,
  input  wire logic                             fb_rd_i,
  output logic      [7:0]                       fb_rdata_o,
  output logic                                  fb_rvalid_o
);
  import vgapm_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [3:0] set_reset_ff, en_set_rst_ff, color_cmp_ff, ignore_mask_ff;
  logic [3:0] read_plane_ff, plane_mask_ff;
  logic [7:0] rotate_ff, access_mode_ff, bit_mask_ff;
  logic [31:0] latch_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      set_reset_ff   <= RST_ZERO[3:0];
      en_set_rst_ff  <= RST_ZERO[3:0];
      color_cmp_ff   <= RST_ZERO[3:0];
      ignore_mask_ff <= RST_ZERO[3:0];
      read_plane_ff  <= RST_ZERO[3:0];
      rotate_ff      <= RST_ZERO;
      access_mode_ff <= RST_ACCESS_MODE;
      bit_mask_ff    <= RST_BIT_MASK;
      plane_mask_ff  <= RST_PLANE_MASK;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        REG_SET_RESET:   set_reset_ff   <= reg_wdata_i[3:0];
        REG_EN_SET_RST:  en_set_rst_ff  <= reg_wdata_i[3:0];
        REG_COLOR_CMP:   color_cmp_ff   <= reg_wdata_i[3:0];
        REG_ROTATE:      rotate_ff      <= reg_wdata_i;
        REG_READ_PLANE:  read_plane_ff  <= {2'h0, reg_wdata_i[1:0]};
        // Reserved bit never stored
        REG_ACCESS_MODE: access_mode_ff <= reg_wdata_i & 8'hfb;
        REG_IGNORE_MASK: ignore_mask_ff <= reg_wdata_i[3:0];
        REG_BIT_MASK:    bit_mask_ff    <= reg_wdata_i;
        REG_SEQ_MODE:    plane_mask_ff  <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  logic [1:0] wmode;
  logic       rmode, odd_even;
  assign wmode    = access_mode_ff[FLD_WMODE_LO +: 2];
  assign rmode    = access_mode_ff[FLD_RMODE];
  assign odd_even = access_mode_ff[FLD_ODD_EVEN];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= RST_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_SET_RESET:   reg_rdata_o <= {4'h0, set_reset_ff};
        REG_EN_SET_RST:  reg_rdata_o <= {4'h0, en_set_rst_ff};
        REG_COLOR_CMP:   reg_rdata_o <= {4'h0, color_cmp_ff};
        REG_ROTATE:      reg_rdata_o <= rotate_ff;
        REG_READ_PLANE:  reg_rdata_o <= {4'h0, read_plane_ff};
        REG_ACCESS_MODE: reg_rdata_o <= access_mode_ff & 8'hfb;
        REG_IGNORE_MASK: reg_rdata_o <= {4'h0, ignore_mask_ff};
        REG_BIT_MASK:    reg_rdata_o <= bit_mask_ff;
        REG_SEQ_MODE:    reg_rdata_o <= {4'h0, plane_mask_ff};
        REG_LATCH0:      reg_rdata_o <= latch_ff[7:0];
        default:         reg_rdata_o <= RST_ZERO;
      endcase
    end
  end

  // ************************************************************
  // Address mapping
  // ************************************************************
  logic [ADDR_W-1:0] mem_addr;
  logic [3:0]        plane_en;

  always_comb begin
    if (odd_even) begin
      // Bit 0 leaves the address and steers the plane pair
      mem_addr = {1'b0, fb_addr_i[ADDR_W-1:1]};
      plane_en = fb_addr_i[0] ? 4'ha : 4'h5;
    end else begin
      mem_addr = fb_addr_i;
      plane_en = plane_mask_ff;
    end
  end

  // ************************************************************
  // Write datapath
  // ************************************************************
  function automatic logic [7:0] ror8(input logic [7:0] d,
                                      input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] m,
                                       input logic [7:0] a,
                                       input logic [7:0] b);
    return (a & m) | (b & ~m);
  endfunction

  logic [7:0]  rot_byte, m3;
  logic [31:0] wdata;
  assign rot_byte = ror8(fb_wdata_i, rotate_ff[FLD_ROT_HI:0]);
  assign m3       = fb_wdata_i & bit_mask_ff;

  always_comb begin
    wdata = latch_ff;
    for (int p = 0; p < 4; p++) begin
      case (wmode)
        WMODE_0: wdata[p*8 +: 8] = en_set_rst_ff[p] ?
                   {8{set_reset_ff[p]}} : rot_byte;
        WMODE_1: wdata[p*8 +: 8] = latch_ff[p*8 +: 8];
        WMODE_2: wdata[p*8 +: 8] = merge(bit_mask_ff,
                   {8{fb_wdata_i[p]}}, latch_ff[p*8 +: 8]);
        WMODE_3: wdata[p*8 +: 8] = merge(m3,
                   {8{set_reset_ff[p]}}, latch_ff[p*8 +: 8]);
        default: wdata[p*8 +: 8] = latch_ff[p*8 +: 8];
      endcase
    end
  end

  logic [31:0] mem_rdata;

  vgapm_plane_mem #(.AW(ADDR_W)) u_mem (
    .clk_i   (clk_i),
    .addr_i  (mem_addr),
    .wr_i    (fb_wr_i),
    .we_i    (plane_en),
    .wdata_i (wdata),
    .rdata_o (mem_rdata)
  );

  // ************************************************************
  // Read datapath and latches
  // ************************************************************
  logic rd_pend_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rd_pend_ff <= 1'b0;
    else          rd_pend_ff <= fb_rd_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)        latch_ff <= 32'h0000_0000;
    else if (rd_pend_ff) latch_ff <= mem_rdata;
  end

  // Plane chosen for a read: read plane select bits 1:0, captured with the read; the address bit plays no part, even in odd/even
  logic [1:0] rd_plane_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)     rd_plane_ff <= 2'h0;
    else if (fb_rd_i) rd_plane_ff <= read_plane_ff[1:0];
  end

  logic [7:0] cmp_res;
  always_comb begin
    cmp_res = 8'hff;
    for (int p = 0; p < 4; p++) begin
      if (ignore_mask_ff[p]) begin
        cmp_res = cmp_res &
          ~(mem_rdata[p*8 +: 8] ^ {8{color_cmp_ff[p]}});
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_rdata_o  <= 8'h00;
      fb_rvalid_o <= 1'b0;
    end else begin
      fb_rvalid_o <= rd_pend_ff;
      if (rd_pend_ff) begin
        fb_rdata_o <= rmode ? cmp_res :
                      mem_rdata[rd_plane_ff*8 +: 8];
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // Set/reset and colour bits spread over whole plane bytes
  logic [31:0] sr_bytes, color_bytes;
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      sr_bytes[p*8 +: 8]    = {8{set_reset_ff[p]}};
      color_bytes[p*8 +: 8] = {8{fb_wdata_i[p]}};
    end
  end

  chk_rsvd_bit_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == REG_ACCESS_MODE |=> !reg_rdata_o[2])
    else $error("reserved mode bit read as one");
  chk_rsvd_not_kept: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !access_mode_ff[FLD_RSVD])
    else $error("reserved mode bit stored");
  chk_latch_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_pend_ff |=> latch_ff == $past(mem_rdata))
    else $error("read latches missed the read");
  chk_oddeven_planes: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    odd_even |-> plane_en == (fb_addr_i[0] ? 4'ha : 4'h5))
    else $error("odd/even plane select wrong");
  chk_oddeven_addr: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    odd_even |-> mem_addr[ADDR_W-2:0] == fb_addr_i[ADDR_W-1:1] &&
      !mem_addr[ADDR_W-1])
    else $error("odd/even address not halved");
  chk_linear_planes: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !odd_even |-> mem_addr == fb_addr_i && plane_en == plane_mask_ff)
    else $error("linear addressing wrong");
  chk_rvalid_timing: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    fb_rd_i |-> ##2 fb_rvalid_o)
    else $error("read answer not two cycles later");
  chk_rvalid_cause: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    fb_rvalid_o |-> $past(fb_rd_i, 2))
    else $error("read answer without a read");
  chk_rmode0_plane: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_pend_ff && !rmode && rd_plane_ff == 2'h0 |=>
      fb_rdata_o == $past(mem_rdata[7:0]))
    else $error("read mode 0 plane 0 byte wrong");
  chk_rmode1_none: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_pend_ff && rmode && ignore_mask_ff == 4'h0 |=>
      fb_rdata_o == 8'hff)
    else $error("compare with no planes not all ones");
  chk_cmp_all: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ignore_mask_ff == 4'h0 |-> cmp_res == 8'hff)
    else $error("empty compare not all ones");
  chk_wm0_plain: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_0 && rotate_ff[FLD_ROT_HI:0] == 3'h0 &&
      !en_set_rst_ff[1] |-> wdata[15:8] == fb_wdata_i)
    else $error("write mode 0 plane 1 not host byte");
  chk_wm0_setreset: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_0 && en_set_rst_ff[0] |->
      wdata[7:0] == {8{set_reset_ff[0]}})
    else $error("set/reset not applied plane 0");
  chk_wm1_latch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_1 |-> wdata == latch_ff)
    else $error("write mode 1 not from latches");
  chk_wm2_color: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_2 && bit_mask_ff == 8'hff |-> wdata == color_bytes)
    else $error("write mode 2 colour not spread");
  chk_wm2_keep: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_2 |->
      ((wdata ^ latch_ff) & ~{4{bit_mask_ff}}) == 32'h0)
    else $error("write mode 2 changed masked-off bits");
  chk_wm3_set: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_3 |-> ((wdata ^ sr_bytes) &
      {4{fb_wdata_i & bit_mask_ff}}) == 32'h0)
    else $error("write mode 3 set/reset not written");
  chk_wm3_keep: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wmode == WMODE_3 |-> ((wdata ^ latch_ff) &
      ~{4{fb_wdata_i & bit_mask_ff}}) == 32'h0)
    else $error("write mode 3 changed unmasked bits");

  // ************************************************************
  // Scenario coverage
  // ************************************************************
  cov_read_m0:  cover property (@(posedge clk_i) rd_pend_ff && !rmode);
  cov_read_m1:  cover property (@(posedge clk_i) rd_pend_ff && rmode);
  cov_write_m2: cover property (@(posedge clk_i) fb_wr_i && wmode == WMODE_2);
  cov_write_m3: cover property (@(posedge clk_i) fb_wr_i && wmode == WMODE_3);
  cov_oe_write: cover property (@(posedge clk_i) fb_wr_i && odd_even);
endmodule // vgapm_top
`default_nettype wire

// ### testbench/vgapm_host_bfm.sv
// Host processor model issuing register and frame buffer cycles
`timescale 1ns/1ps
`default_nettype none
module vgapm_host_bfm
  import vgapm_pkg::*;
(
  input  wire logic                            clk_i,
  output var logic [vgapm_pkg::REG_ADDR_W-1:0] reg_addr_o,
  output var logic [7:0]                       reg_wdata_o,
  output var logic                             reg_wr_o,
  output var logic                             reg_rd_o,
  input  wire logic [7:0]                      reg_rdata_i,
  output var logic [vgapm_pkg::ADDR_W-1:0]     fb_addr_o,
  output var logic [7:0]                       fb_wdata_o,
  output var logic                             fb_wr_o,
  output var logic                             fb_rd_o,
  input  wire logic [7:0]                      fb_rdata_i,
  input  wire logic                            fb_rvalid_i
);
  initial begin
    {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
    {fb_addr_o, fb_wdata_o, fb_wr_o, fb_rd_o} = '0;
  end
  // ****************************************
  // Bus cycles
  // ****************************************
  // Idle address and data are inverted so no stale value looks valid
  task automatic reg_access(input logic w, input logic [3:0] a,
                            input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= w;
    reg_rd_o    <= !w;
    @(posedge clk_i);
    {reg_wr_o, reg_rd_o} <= 2'b00;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
    #1 q = reg_rdata_i;
  endtask
  task automatic fb_access(input logic w, input logic [15:0] a,
                           input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    fb_addr_o  <= a;
    fb_wdata_o <= d;
    fb_wr_o    <= w;
    fb_rd_o    <= !w;
    @(posedge clk_i);
    {fb_wr_o, fb_rd_o} <= 2'b00;
    fb_addr_o  <= ~a;
    fb_wdata_o <= ~d;
    q = 8'hxx;
    // Result waited for under a bound; a read also leaves the latch gap
    for (int i = 0; i < 4 && !w; i++) begin
      @(posedge clk_i);
      #1 if (fb_rvalid_i === 1'b1) begin
        q = fb_rdata_i;
        break;
      end
    end
  endtask
endmodule // vgapm_host_bfm
`default_nettype wire

// ### testbench/tb.sv
// Self-checking testbench of the plane read/write mode datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module tb;
  import vgapm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, fb_wdata, fb_rdata, q;
  logic reg_wr, reg_rd, fb_wr, fb_rd, fb_rvalid;
  logic [15:0] fb_addr;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  vgapm_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .fb_addr_i(fb_addr), .fb_wdata_i(fb_wdata),
    .fb_wr_i(fb_wr), .fb_rd_i(fb_rd), .fb_rdata_o(fb_rdata),
    .fb_rvalid_o(fb_rvalid));
  vgapm_host_bfm u_host (.clk_i(clk_i), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata), .fb_addr_o(fb_addr), .fb_wdata_o(fb_wdata),
    .fb_wr_o(fb_wr), .fb_rd_o(fb_rd), .fb_rdata_i(fb_rdata),
    .fb_rvalid_i(fb_rvalid));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.reg_access(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    u_host.reg_access(1'b0, a, 8'h00, q);
    `CHK("register", e, q)
  endtask
  task automatic fbw(input logic [15:0] a, input logic [7:0] d);
    u_host.fb_access(1'b1, a, d, q);
  endtask
  task automatic planes(input logic [15:0] a, input logic [31:0] e);
    for (int p = 0; p < 4; p++) begin
      wr(REG_READ_PLANE, 8'(p));
      u_host.fb_access(1'b0, a, 8'h00, q);
      `CHK("plane byte", e[8*p +: 8], q)
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd_chk(REG_ACCESS_MODE, 8'h00);
    rd_chk(REG_BIT_MASK, 8'hff);
    rd_chk(4'h6, 8'h00);
    wr(REG_ACCESS_MODE, 8'h0f);
    rd_chk(REG_ACCESS_MODE, 8'h0b);
  endtask
  task automatic t_wmode0;
    wr(REG_ACCESS_MODE, 8'h00);
    wr(REG_ROTATE, 8'h03);
    wr(REG_EN_SET_RST, 8'h05);
    wr(REG_SET_RESET, 8'h01);
    fbw(16'h000a, 8'ha5);
    planes(16'h000a, 32'hb400b4ff);
  endtask
  task automatic t_rmode1;
    logic [3:0] cmp [4] = '{4'hb, 4'h0, 4'h0, 4'h5};
    logic [3:0] ign [4] = '{4'hf, 4'h4, 4'h2, 4'h0};
    logic [7:0] e   [4] = '{8'hb4, 8'hff, 8'h4b, 8'hff};
    wr(REG_ACCESS_MODE, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(REG_COLOR_CMP, {4'h0, cmp[i]});
      wr(REG_IGNORE_MASK, {4'h0, ign[i]});
      u_host.fb_access(1'b0, 16'h000a, 8'h00, q);
      `CHK("compare", e[i], q)
    end
    rd_chk(REG_LATCH0, 8'hff);
  endtask
  task automatic t_wmode123;
    wr(REG_ACCESS_MODE, 8'h01);
    fbw(16'h0014, 8'h00);
    planes(16'h0014, 32'hb400b4ff);
    wr(REG_ACCESS_MODE, 8'h02);
    wr(REG_BIT_MASK, 8'h0f);
    fbw(16'h001e, 8'hf6);
    planes(16'h001e, 32'hb00fbff0);
    wr(REG_ACCESS_MODE, 8'h03);
    wr(REG_SET_RESET, 8'h05);
    wr(REG_BIT_MASK, 8'h3c);
    fbw(16'h0028, 8'hf0);
    planes(16'h0028, 32'h803f8ff0);
  endtask
  task automatic t_oddeven;
    wr(REG_ACCESS_MODE, 8'h10);
    wr(REG_ROTATE, 8'h00);
    wr(REG_EN_SET_RST, 8'h00);
    fbw(16'h0065, 8'h3c);
    fbw(16'h0064, 8'hc3);
    planes(16'h0064, 32'h3cc33cc3);
    wr(REG_ACCESS_MODE, 8'h00);
    wr(REG_SEQ_MODE, 8'h02);
    fbw(16'h0032, 8'h5a);
    wr(REG_SEQ_MODE, 8'h0f);
    planes(16'h0032, 32'h3cc35ac3);
  endtask
  initial begin
    #20us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_wmode0();
    t_rmode1();
    t_wmode123();
    t_oddeven();
    end_of_test();
  end
endmodule // tb
`undef CHK
`default_nettype wire
